// ==== hw/dcf_pkg.sv ====
// Package for the command/address/clock-enable front end.
// Assumes one 200 MHz core clock standing in for the positive CK crossing.
package dcf_pkg;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int MR_SEL_W = 2;
  localparam int AP_BIT = 10;
  localparam int CLK_MHZ = 200;
  // Mode register select codes
  localparam logic [1:0] MR_BASE = 2'h0;
  localparam logic [1:0] MR_EXT1 = 2'h1;
  localparam logic [1:0] MR_EXT2 = 2'h2;
  localparam logic [1:0] MR_EXT3 = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [NBANK-1:0] BANKS_IDLE = 4'h0;

  // Internal command code, decoded from {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    DCF_CMD_NOP = 3'b000,
    DCF_CMD_ACT = 3'b001,
    DCF_CMD_RD = 3'b010,
    DCF_CMD_WR = 3'b011,
    DCF_CMD_PRE = 3'b100,
    DCF_CMD_REF = 3'b101,
    DCF_CMD_LMR = 3'b110
  } dcf_cmd_e;

  typedef enum logic [1:0] {
    DCF_ST_ACTIVE = 2'b00,
    DCF_ST_PPD = 2'b01,
    DCF_ST_APD = 2'b10,
    DCF_ST_SREF = 2'b11
  } dcf_pwr_e;

  // Pins from the controller
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic odt;
  } dcf_pins_s;

  // Decoded command toward the core
  typedef struct packed {
    logic valid;
    dcf_cmd_e cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic auto_pre;
    logic all_banks;
    logic [MR_SEL_W-1:0] mr_sel;
    logic [ADDR_W-1:0] opcode;
  } dcf_dec_s;
endpackage

// ==== hw/dcf_cke_sync.sv ====
// Three-stage synchroniser for the clock-enable pin.
// Assumes cke arrives asynchronously to clk.
`timescale 1ns/1ps
module dcf_cke_sync (
  input wire logic clk, // Core clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic cke_pin, // Raw clock-enable
  output logic cke_stable, // Agreed level
  output logic cke_async_hi // Stage-2 high, for self-refresh wake
);
  typedef struct packed {
    logic [2:0] sh;
    logic st;
  } dcf_sync_s;
  dcf_sync_s s_q, s_d;

  // Shift and accept when stages 2 and 3 agree
  always_comb begin
    s_d = s_q;
    s_d.sh = {s_q.sh[1:0], cke_pin};
    if (s_q.sh[1] == s_q.sh[2]) begin
      s_d.st = s_q.sh[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cke_stable = s_q.st;
  assign cke_async_hi = s_q.sh[1]; // [R12]
endmodule

// ==== hw/dcf_front_end.sv ====
// Command/address decode and power-state tracking for a 4-bank DRAM.
// Assumes the controller holds cke low until init and drives valid codes.
`timescale 1ns/1ps
// Operation
// [R1] ACTIVATE latches the address as the row to open in the bank.
// [R2] READ/WRITE take the column address; A10 requests auto precharge.
// [R3] PRECHARGE closes the addressed bank if A10 low, all banks if high.
// [R4] LOAD MODE delivers the address inputs as the mode op-code.
// [R5] Bank address selects bank for ACTIVATE, READ, WRITE, PRECHARGE.
// [R6] During LOAD MODE bank address selects one of four mode registers.
// [R7] Inputs are sampled only on the rising clock edge.
// [R8] Outputs are timed from the same rising clock edge.
// [R9] Clock-enable high enables internal clocking, low disables it.
// [R10] Cke low: precharge power-down or self refresh idle, else active.
// [R11] Clock-enable is sampled synchronously for entry and power-down exit.
// [R12] Self-refresh exit is taken from clock-enable without clock sampling; code takes it from synchroniser stage 2, sampled on clk.
// [R13] Power-down gates all receivers except clock, cke and termination.
// [R14] Self refresh gates every receiver except clock-enable.
// [R15] Chip select low enables decode; high masks every command.
// [R16] Row, column and write strobes with chip select form the code.
// [R17] Controller holds clock-enable low until the clock is stable.
module dcf_front_end (
  input wire logic clk, // 200 MHz core clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic cke, // Clock-enable pin
  input dcf_pkg::dcf_pins_s pins, // Command, address, odt pins
  output dcf_pkg::dcf_dec_s dec, // Decoded command, one-cycle valid
  output logic [dcf_pkg::NBANK-1:0] open_banks, // Banks with open row
  output dcf_pkg::dcf_pwr_e pwr_state, // Current power state
  output logic clk_en, // Internal clocking enabled
  output logic odt_q, // Registered termination request
  output logic [dcf_pkg::ADDR_W-1:0] mr_base, // Base mode register
  output logic [dcf_pkg::ADDR_W-1:0] mr_ext1, // Extended mode reg 1
  output logic [dcf_pkg::ADDR_W-1:0] mr_ext2, // Extended mode reg 2
  output logic [dcf_pkg::ADDR_W-1:0] mr_ext3 // Extended mode reg 3
);
  typedef struct packed {
    dcf_pkg::dcf_dec_s dec;
    logic [dcf_pkg::NBANK-1:0] open;
    dcf_pkg::dcf_pwr_e pwr;
    logic clk_en;
    logic odt;
    logic [dcf_pkg::ADDR_W-1:0] mr0;
    logic [dcf_pkg::ADDR_W-1:0] mr1;
    logic [dcf_pkg::ADDR_W-1:0] mr2;
    logic [dcf_pkg::ADDR_W-1:0] mr3;
    logic cke_prev;
  } dcf_state_s;

  dcf_state_s s_q, s_d;
  logic cke_s;
  logic cke_wake;

  // Command code from the four strobes
  function automatic dcf_pkg::dcf_cmd_e decode(input logic cs_n,
      input logic ras_n, input logic cas_n, input logic we_n);
    dcf_pkg::dcf_cmd_e c;
    c = dcf_pkg::DCF_CMD_NOP;
    if (cs_n) begin
      c = dcf_pkg::DCF_CMD_NOP; // [R15]
    end else if ({ras_n, cas_n, we_n} == 3'b011) begin
      c = dcf_pkg::DCF_CMD_ACT; // [R16]
    end else if ({ras_n, cas_n, we_n} == 3'b101) begin
      c = dcf_pkg::DCF_CMD_RD;
    end else if ({ras_n, cas_n, we_n} == 3'b100) begin
      c = dcf_pkg::DCF_CMD_WR;
    end else if ({ras_n, cas_n, we_n} == 3'b010) begin
      c = dcf_pkg::DCF_CMD_PRE;
    end else if ({ras_n, cas_n, we_n} == 3'b001) begin
      c = dcf_pkg::DCF_CMD_REF;
    end else if ({ras_n, cas_n, we_n} == 3'b000) begin
      c = dcf_pkg::DCF_CMD_LMR;
    end
    return c;
  endfunction

  // Auto-precharge / all-bank flag carried on the address
  function automatic logic ap_flag(
      input logic [dcf_pkg::ADDR_W-1:0] a);
    return a[dcf_pkg::AP_BIT];
  endfunction

  // One-hot mask of the addressed bank
  function automatic logic [dcf_pkg::NBANK-1:0] bank_mask(
      input logic [dcf_pkg::BANK_W-1:0] b);
    logic [dcf_pkg::NBANK-1:0] m;
    m = '0;
    m[b] = 1'b1;
    return m;
  endfunction

  // Reset image: active, clocking off, no open rows, mode regs cleared
  function automatic dcf_state_s rst_state();
    dcf_state_s r;
    r = '0;
    r.pwr = dcf_pkg::DCF_ST_ACTIVE;
    r.clk_en = 1'b0;
    r.open = dcf_pkg::BANKS_IDLE;
    r.mr0 = dcf_pkg::ADDR_RST;
    r.mr1 = dcf_pkg::ADDR_RST;
    r.mr2 = dcf_pkg::ADDR_RST;
    r.mr3 = dcf_pkg::ADDR_RST;
    r.dec.cmd = dcf_pkg::DCF_CMD_NOP;
    return r;
  endfunction

  dcf_cke_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .cke_pin(cke),
    .cke_stable(cke_s),
    .cke_async_hi(cke_wake)
  );

  // Next state: decode, bank tracking, power states
  always_comb begin
    dcf_pkg::dcf_cmd_e c;
    logic live;
    c = decode(pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n);
    // Command and address receivers live only while clocking is on
    live = (s_q.pwr == dcf_pkg::DCF_ST_ACTIVE) && cke_s; // [R13]
    s_d = s_q;
    s_d.cke_prev = cke_s;
    s_d.dec.valid = 1'b0;
    // Termination receiver stays on in power-down, not in self refresh
    if (s_q.pwr != dcf_pkg::DCF_ST_SREF) begin
      s_d.odt = pins.odt; // [R13]
    end
    if (live && c != dcf_pkg::DCF_CMD_NOP) begin // [R7]
      s_d.dec.valid = 1'b1;
      s_d.dec.cmd = c;
      s_d.dec.bank = pins.bank; // [R5]
      s_d.dec.auto_pre = 1'b0;
      s_d.dec.all_banks = 1'b0;
      case (c)
        dcf_pkg::DCF_CMD_ACT: begin
          s_d.dec.row = pins.addr; // [R1]
          s_d.open = s_d.open | bank_mask(pins.bank);
        end
        dcf_pkg::DCF_CMD_RD, dcf_pkg::DCF_CMD_WR: begin
          s_d.dec.col = pins.addr; // [R2]
          s_d.dec.auto_pre = ap_flag(pins.addr); // [R2]
          if (ap_flag(pins.addr)) begin
            s_d.open = s_d.open & ~bank_mask(pins.bank);
          end
        end
        dcf_pkg::DCF_CMD_PRE: begin
          if (ap_flag(pins.addr)) begin
            s_d.dec.all_banks = 1'b1; // [R3]
            s_d.open = dcf_pkg::BANKS_IDLE;
          end else begin
            s_d.open = s_d.open & ~bank_mask(pins.bank); // [R3]
          end
        end
        dcf_pkg::DCF_CMD_LMR: begin
          s_d.dec.mr_sel = pins.bank; // [R6]
          s_d.dec.opcode = pins.addr; // [R4]
          if (pins.bank == dcf_pkg::MR_BASE) begin
            s_d.mr0 = pins.addr;
          end else if (pins.bank == dcf_pkg::MR_EXT1) begin
            s_d.mr1 = pins.addr;
          end else if (pins.bank == dcf_pkg::MR_EXT2) begin
            s_d.mr2 = pins.addr;
          end else begin
            s_d.mr3 = pins.addr;
          end
        end
        default: begin
        end
      endcase
    end
    // Power states from clock-enable
    case (s_q.pwr)
      dcf_pkg::DCF_ST_ACTIVE: begin
        if (!cke_s && s_q.cke_prev) begin // [R11]
          if (s_q.open != dcf_pkg::BANKS_IDLE) begin
            s_d.pwr = dcf_pkg::DCF_ST_APD; // [R10]
          end else if (c == dcf_pkg::DCF_CMD_REF) begin
            s_d.pwr = dcf_pkg::DCF_ST_SREF; // [R10]
          end else begin
            s_d.pwr = dcf_pkg::DCF_ST_PPD; // [R10]
          end
          s_d.dec.valid = 1'b0;
        end
      end
      dcf_pkg::DCF_ST_PPD, dcf_pkg::DCF_ST_APD: begin
        if (cke_s) begin
          s_d.pwr = dcf_pkg::DCF_ST_ACTIVE; // [R11]
        end
      end
      dcf_pkg::DCF_ST_SREF: begin
        if (cke_wake) begin
          s_d.pwr = dcf_pkg::DCF_ST_ACTIVE; // [R12]
        end
      end
      default: s_d.pwr = dcf_pkg::DCF_ST_ACTIVE;
    endcase
    // Self refresh ignores everything but clock-enable
    if (s_q.pwr == dcf_pkg::DCF_ST_SREF) begin
      s_d.dec.valid = 1'b0; // [R14]
    end
    // Clocking only while active and clock-enable agreed high
    s_d.clk_en = (s_d.pwr == dcf_pkg::DCF_ST_ACTIVE) && cke_s; // [R9]
  end

  // State register
  always_ff @(posedge clk) begin // [R8]
    if (!nrst) begin
      s_q <= rst_state();
    end else begin
      s_q <= s_d;
    end
  end

  assign dec = s_q.dec;
  assign open_banks = s_q.open;
  assign pwr_state = s_q.pwr;
  assign clk_en = s_q.clk_en;
  assign odt_q = s_q.odt;
  assign mr_base = s_q.mr0;
  assign mr_ext1 = s_q.mr1;
  assign mr_ext2 = s_q.mr2;
  assign mr_ext3 = s_q.mr3;
endmodule

// ==== tb/dcf_checker.sv ====
// Assertions on the command front end ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module dcf_checker (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset
  input wire logic cke, // Clock-enable
  input dcf_pkg::dcf_pins_s pins, // Pins
  input dcf_pkg::dcf_dec_s dec, // Decoded command
  input wire logic [3:0] open_banks, // Open rows
  input dcf_pkg::dcf_pwr_e pwr_state, // Power state
  input wire logic clk_en, // Clocking on
  input wire logic odt_q, // Termination
  input wire logic [13:0] mr_base, // Base mode
  input wire logic [13:0] mr_ext1, // Ext 1
  input wire logic [13:0] mr_ext2, // Ext 2
  input wire logic [13:0] mr_ext3 // Ext 3
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Count of cycles cke has stayed high
  logic [2:0] run_q;
  always_ff @(posedge clk)
    run_q <= (!nrst || !cke) ? 3'h0 : run_q + {2'h0, run_q != 3'h7};
  // Decode helpers
  wire ok = clk_en && run_q > 3'h4;
  wire a10 = pins.addr[10];
  wire [2:0] code = {pins.ras_n, pins.cas_n, pins.we_n};
  wire [13:0] mr = dec.mr_sel[1] ? (dec.mr_sel[0] ? mr_ext3 : mr_ext2)
    : (dec.mr_sel[0] ? mr_ext1 : mr_base);
  sequence s_take(c); ok && !pins.cs_n && code == c; endsequence
  sequence s_col; ok && !pins.cs_n && code[2:1] == 2'h2; endsequence
  sequence s_wake; pwr_state == dcf_pkg::DCF_ST_SREF && cke ##1 cke [*4];
  endsequence
  row_open_a: assert property (s_take(3'h3) |=> dec.valid &&
    dec.row == $past(pins.addr) && open_banks[$past(pins.bank)])
    else $error("activate not decoded");
  col_flag_a: assert property (s_col |=> dec.col == $past(pins.addr) &&
    dec.auto_pre == $past(a10)) else $error("column or flag wrong");
  pre_scope_a: assert property (s_take(3'h2) |=>
    ($past(a10) ? open_banks == 4'h0 : !open_banks[$past(pins.bank)]))
    else $error("precharge scope wrong");
  mode_load_a: assert property (s_take(3'h0) |=>
    dec.mr_sel == $past(pins.bank) && mr == $past(pins.addr))
    else $error("mode register load wrong");
  cs_mask_a: assert property (pins.cs_n |=> !dec.valid)
    else $error("deselected command decoded");
  pd_gate_a: assert property (pwr_state != dcf_pkg::DCF_ST_ACTIVE
    |=> !dec.valid) else $error("command taken in low power");
  clk_gate_a: assert property (pwr_state != dcf_pkg::DCF_ST_ACTIVE
    |-> !clk_en) else $error("clocking on in low power");
  pd_enter_a: assert property (!cke [*6] |-> !clk_en)
    else $error("cke low not obeyed");
  pd_kind_a: assert property (pwr_state != dcf_pkg::DCF_ST_ACTIVE &&
    $past(pwr_state) == dcf_pkg::DCF_ST_ACTIVE |-> (pwr_state ==
    dcf_pkg::DCF_ST_APD) == ($past(open_banks) != 4'h0))
    else $error("wrong power-down kind");
  sref_wake_a: assert property (s_wake |->
    pwr_state != dcf_pkg::DCF_ST_SREF) else $error("self refresh stuck");
  odt_track_a: assert property (pwr_state != dcf_pkg::DCF_ST_SREF
    |=> odt_q == $past(pins.odt)) else $error("termination not tracked");
  odt_hold_a: assert property (pwr_state == dcf_pkg::DCF_ST_SREF
    |=> $stable(odt_q)) else $error("termination moved in self refresh");
endmodule
bind dcf_front_end dcf_checker chk (.clk(clk), .nrst(nrst), .cke(cke),
  .pins(pins), .dec(dec), .open_banks(open_banks), .pwr_state(pwr_state),
  .clk_en(clk_en), .odt_q(odt_q), .mr_base(mr_base), .mr_ext1(mr_ext1),
  .mr_ext2(mr_ext2), .mr_ext3(mr_ext3));

// ==== tb/dcf_ctrl_model.sv ====
// Memory controller model driving command, address and cke.
// Assumes it changes pins only at falling clock edges.
`timescale 1ns/1ps
module dcf_ctrl_model (
  input wire logic clk, // Clock
  output dcf_pkg::dcf_pins_s pins, // Command pins
  output logic cke // Clock-enable
);
  // Deselected, cke low until init
  initial begin
    pins = '0;
    pins.cs_n = 1'b1;
    cke = 1'b0;
  end
  // Command held n cycles, then deselected with bank and address inverted
  task automatic issue(input logic cs, input logic [2:0] c,
      input logic [1:0] ba, input logic [13:0] a, input int n);
    @(negedge clk);
    pins.cs_n = cs;
    {pins.ras_n, pins.cas_n, pins.we_n} = c;
    pins.bank = ba;
    pins.addr = a;
    repeat (n) @(negedge clk);
    pins.cs_n = 1'b1;
    pins.bank = ~ba;
    pins.addr = ~a;
  endtask
  // Synchronous cke change
  task automatic drive_cke(input logic v);
    @(negedge clk);
    cke = v;
  endtask
  // Termination request change
  task automatic drive_odt(input logic v);
    @(negedge clk);
    pins.odt = v;
  endtask
endmodule

// ==== tb/tb_dcf_front_end.sv ====
// Self-checking bench for the command front end.
// Assumes the controller model drives every pin.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t mismatch", $time); end end
module tb_dcf_front_end;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cke;
  int n_errors = 0;
  int checked = 0;
  dcf_pkg::dcf_pins_s pins;
  dcf_pkg::dcf_dec_s dec;
  logic [3:0] open_banks;
  dcf_pkg::dcf_pwr_e pwr_state;
  logic clk_en;
  logic odt_q;
  logic [13:0] mr [4];
  always #2.5 clk = ~clk;
  dcf_front_end dut (.clk(clk), .nrst(nrst), .cke(cke), .pins(pins),
    .dec(dec), .open_banks(open_banks), .pwr_state(pwr_state),
    .clk_en(clk_en), .odt_q(odt_q), .mr_base(mr[0]), .mr_ext1(mr[1]),
    .mr_ext2(mr[2]), .mr_ext3(mr[3]));
  dcf_ctrl_model ctl (.clk(clk), .pins(pins), .cke(cke));
  // Bounded wait for a power state
  task automatic wait_pwr(input dcf_pkg::dcf_pwr_e e);
    for (int k = 0; k < 12 && pwr_state !== e; k++) @(negedge clk);
    `CHK(pwr_state, e)
  endtask
  // Activate, then column accesses with and without auto precharge
  task automatic t_rw();
    ctl.issue(1'b0, 3'h3, 2'h1, 14'h1a5c, 1);
    `CHK(dec.row, 14'h1a5c)
    `CHK(dec.valid, 1'b1)
    `CHK(dec.cmd, dcf_pkg::DCF_CMD_ACT)
    `CHK(dec.bank, 2'h1)
    `CHK(open_banks, 4'h2)
    ctl.issue(1'b0, 3'h4, 2'h1, 14'h0123, 1);
    `CHK(dec.col, 14'h0123)
    ctl.issue(1'b0, 3'h5, 2'h1, 14'h0400, 1);
    `CHK(dec.auto_pre, 1'b1)
    `CHK(dec.cmd, dcf_pkg::DCF_CMD_RD)
    `CHK(open_banks, 4'h0)
  endtask
  // Single-bank then all-bank precharge, and a masked command
  task automatic t_pre();
    ctl.issue(1'b0, 3'h3, 2'h0, 14'h0011, 1);
    ctl.issue(1'b0, 3'h3, 2'h2, 14'h0022, 1);
    ctl.issue(1'b0, 3'h2, 2'h0, 14'h0000, 1);
    `CHK(open_banks, 4'h4)
    ctl.issue(1'b0, 3'h2, 2'h3, 14'h0400, 1);
    `CHK(open_banks, 4'h0)
    `CHK(dec.all_banks, 1'b1)
    ctl.issue(1'b1, 3'h3, 2'h3, 14'h0fff, 1);
    `CHK(open_banks, 4'h0)
    `CHK(dec.valid, 1'b0)
  endtask
  // Load all four mode registers
  task automatic t_lmr();
    for (int i = 0; i < 4; i++)
      ctl.issue(1'b0, 3'h0, 2'(i), 14'h2a50 + 14'(i), 1);
    `CHK(dec.mr_sel, 2'h3)
    `CHK(dec.opcode, 14'h2a53)
    for (int i = 0; i < 4; i++) `CHK(mr[i], 14'h2a50 + 14'(i))
  endtask
  // Active and precharge power-down, then self refresh
  task automatic t_pwr();
    ctl.issue(1'b0, 3'h3, 2'h3, 14'h0777, 1);
    ctl.drive_cke(1'b0);
    wait_pwr(dcf_pkg::DCF_ST_APD);
    `CHK(clk_en, 1'b0)
    ctl.drive_odt(1'b1);
    ctl.issue(1'b0, 3'h2, 2'h3, 14'h0400, 1);
    `CHK(open_banks, 4'h8)
    `CHK(odt_q, 1'b1)
    ctl.drive_cke(1'b1);
    wait_pwr(dcf_pkg::DCF_ST_ACTIVE);
    ctl.issue(1'b0, 3'h2, 2'h3, 14'h0400, 1);
    ctl.drive_cke(1'b0);
    wait_pwr(dcf_pkg::DCF_ST_PPD);
    ctl.drive_cke(1'b1);
    wait_pwr(dcf_pkg::DCF_ST_ACTIVE);
    ctl.drive_cke(1'b0);
    ctl.issue(1'b0, 3'h1, 2'h0, 14'h0000, 6);
    wait_pwr(dcf_pkg::DCF_ST_SREF);
    ctl.drive_odt(1'b0);
    ctl.issue(1'b0, 3'h3, 2'h0, 14'h0001, 1);
    `CHK(open_banks, 4'h0)
    `CHK(odt_q, 1'b1)
    ctl.drive_cke(1'b1);
    wait_pwr(dcf_pkg::DCF_ST_ACTIVE);
    @(negedge clk);
    `CHK(odt_q, 1'b0)
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    ctl.drive_cke(1'b1);
    for (int k = 0; k < 12 && clk_en !== 1'b1; k++) @(negedge clk);
    `CHK(clk_en, 1'b1)
    t_rw();
    t_pre();
    t_lmr();
    t_pwr();
    tally_and_finish();
  end
  // Watchdog at 4000 cycles, far beyond the hundred or so cycles the tests need
  initial begin
    #20000;
    n_errors++;
    tally_and_finish();
  end
endmodule
